// >>> rtl/ptc_pkg.sv
package ptc_pkg;

  // register word indices; byte address is four times the index
  localparam logic [2:0] IDX_CLK_CTL = 3'h0;
  localparam logic [2:0] IDX_CNT_CTL = 3'h1;
  localparam logic [2:0] IDX_MAX_VAL = 3'h2;
  localparam logic [2:0] IDX_CNT_VAL = 3'h3;
  localparam logic [2:0] IDX_CNT_STS = 3'h4;

  // channel_clock_control fields
  localparam int CLK_SRC_LSB = 0;
  localparam int CLK_DIV_LSB = 4;
  localparam int CLK_DBG_BIT = 8;

  // counter_control fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_PRESET_BIT = 1;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_ONESHOT_BIT = 3;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_MAX_LOAD_BUSY_BIT = 8;

  // counter_status fields
  localparam int STS_BSY_BIT = 0;
  localparam int STS_DIR_BIT = 1;
  localparam int STS_CAP_LSB = 2;

  // reset values
  localparam logic [15:0] MAX_RST = 16'hffff;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // clock source codes and divider limits
  localparam logic [2:0] SRC_LOW_SPEED = 3'h1;
  localparam logic [2:0] SRC_EXT_OSC = 3'h3;
  localparam logic [3:0] LOW_SPEED_DIV_MAX = 4'h8;
  localparam int PRE_W = 15;

  typedef enum logic [1:0] {
    PTC_UP = 2'h0,
    PTC_DOWN = 2'h1,
    PTC_UPDN = 2'h2,
    PTC_RSVD = 2'h3
  } ptc_mode_t;

  typedef struct packed {
    logic dbgRun;
    logic [3:0] div;
    logic [2:0] src;
  } ptc_clkctl_t;

  typedef struct packed {
    ptc_mode_t mode;
    logic oneShot;
    logic enable;
  } ptc_cntctl_t;

  localparam ptc_clkctl_t CLKCTL_RST = '{1'b0, 4'h0, 3'h0};
  localparam ptc_cntctl_t CNTCTL_RST = '{PTC_UP, 1'b0, 1'b0};

endpackage : ptc_pkg

// >>> rtl/ptc_timer_ctrl.sv
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
// Function
// RULE_01 - debug_run_enable 1 keeps channel clock in debug; 0 withholds it.
// RULE_02 - divide 1/1..1/32768; low-speed only to code 8; external undivided
// RULE_03 - source codes: four oscillators, two external inputs, two inverted
// RULE_04 - sources absent in this build can never be selected; reset loads source code 0 even if it is absent.
// RULE_05 - max_load_busy is 1 while MAX value loads, 0 when writable.
// RULE_06 - software must not write MAX value while max_load_busy is 1.
// RULE_07 - direction mode: 0 up, 1 down, 2 up/down, 3 reserved.
// RULE_08 - one_shot_select 1 runs a single cycle, 0 repeats.
// RULE_09 - writing run 1 starts counting; run reads 1 while counting.
// RULE_10 - writing run 0 while running stops counting.
// RULE_11 - one-shot stop on MAX or zero event clears run by itself.
// RULE_12 - preset in up or up/down clears counter; writing 0 does nothing.
// RULE_13 - preset in down mode loads counter with MAX value.
// RULE_14 - preset reads 1 while counter reset in progress, else 0.
// RULE_15 - preset and run writes honoured only with channel_enable 1.
// RULE_16 - channel_enable 1 supplies operating clock; 0 stops it.
// RULE_17 - 16-bit MAX register resets to all ones, sets limit and preset.
// RULE_18 - software leaves MAX value alone while counting in one-shot.
// RULE_19 - software enables before MAX write, holds enable until busy clears.
// RULE_20 - software never programs a MAX value of zero.
// RULE_21 - read-only live counter value register resets to zero.
// RULE_22 - status bits 2..7 follow capture inputs 0..5.
// RULE_23 - capture level bit high reads 1; absent inputs read 0.
// RULE_24 - direction status 1 while counting up, 0 while counting down.
// RULE_25 - counter_busy_status is 1 while operating, 0 when idle.
module ptc_timer_ctrl
  import ptc_pkg::*;
#(
  parameter logic [5:0] SRC_PRESENT = 6'h3f,
  parameter logic [5:0] CAP_PRESENT = 6'h3f
) (
  input logic core_clk, // system clock, 100 MHz
  input logic rst_n, // async reset, active low
  input logic [2:0] avs_address, // word index
  input logic avs_read, // read request
  input logic avs_write, // write request
  input logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall, low on answer cycle
  input logic debugMode, // system is in debug mode
  input logic internalFastOscTick, // internal_fast_oscillator tick
  input logic lowSpeedOscTick, // low_speed_oscillator tick
  input logic highSpeedOscTick, // high_speed_oscillator tick
  input logic externalOscTick, // external_oscillator_input tick
  input logic extClockInputA, // external_clock_input_a level
  input logic extClockInputB, // external_clock_input_b level
  input logic [5:0] captureInputPin, // capture input levels
  output logic [15:0] countValue, // live counter
  output logic maxEventPulse, // counter reached MAX
  output logic zeroEventPulse // counter reached zero
);

  ptc_clkctl_t clkCtl_ff;
  ptc_cntctl_t cntCtl_ff;
  logic run_ff;
  logic presetBusy_ff;
  logic maxBusy_ff;
  logic [15:0] maxReg_ff;
  logic [15:0] maxBuf_ff;
  logic [15:0] count_ff;
  logic dirUp_ff;
  logic [5:0] capLvl_ff;
  logic extAPrev_ff;
  logic extBPrev_ff;
  logic [PRE_W-1:0] pre_ff;

  logic srcTick;
  logic chanClkOn;
  logic opTick;
  logic runTick;
  logic oneShotStop;
  logic atMax;
  logic atZero;
  logic dirStatus;
  logic busyStatus;
  logic [PRE_W-1:0] mask;
  logic [15:0] regRead;
  logic wrAccept;
  logic clkWr;
  logic ctlWr;
  logic maxWr;
  logic wrEnable;
  ptc_clkctl_t nxt_clkCtl;

  function automatic logic [PRE_W-1:0] divMask(input logic [2:0] src,
                                               input logic [3:0] div);
    logic [3:0] shift;
    shift = div;
    if (src >= SRC_EXT_OSC)
      shift = 4'h0;
    else if (src == SRC_LOW_SPEED && div > LOW_SPEED_DIV_MAX)
      shift = 4'h0;
    divMask = PRE_W'((16'h0001 << shift) - 16'h0001);
  endfunction : divMask

  function automatic logic srcPresent(input logic [2:0] src);
    logic [2:0] idx;
    idx = (src >= 3'h6) ? (src - 3'h2) : src;
    srcPresent = SRC_PRESENT[idx];
  endfunction : srcPresent

  // bus slave: one wait cycle, answer on the cycle waitrequest is low
  assign wrAccept = avs_write && !avs_waitrequest;
  assign clkWr = wrAccept && avs_address == IDX_CLK_CTL;
  assign ctlWr = wrAccept && avs_address == IDX_CNT_CTL;
  assign maxWr = wrAccept && avs_address == IDX_MAX_VAL;
  assign wrEnable = avs_writedata[CTL_EN_BIT];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= {16'h0000, avs_read ? regRead : 16'h0000};
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  assign busyStatus = run_ff || presetBusy_ff || maxBusy_ff; // see RULE_25

  always_comb begin
    dirStatus = 1'b1;
    case (cntCtl_ff.mode)
      PTC_DOWN: dirStatus = 1'b0; // see RULE_24
      PTC_UPDN: dirStatus = dirUp_ff; // see RULE_24
      default: dirStatus = 1'b1;
    endcase
  end

  always_comb begin
    regRead = 16'h0000;
    case (avs_address)
      IDX_CLK_CTL: regRead = {7'h00, clkCtl_ff.dbgRun, clkCtl_ff.div,
                              1'b0, clkCtl_ff.src};
      IDX_CNT_CTL: regRead = {7'h00, maxBusy_ff, 2'h0, cntCtl_ff.mode,
                              cntCtl_ff.oneShot, run_ff, presetBusy_ff,
                              cntCtl_ff.enable}; // see RULE_05 RULE_09 RULE_14
      IDX_MAX_VAL: regRead = maxReg_ff;
      IDX_CNT_VAL: regRead = count_ff; // see RULE_21
      IDX_CNT_STS: regRead = {8'h00, capLvl_ff, dirStatus, busyStatus};
      default: regRead = 16'h0000;
    endcase
  end

  // a source missing from this build leaves the old selection in place
  always_comb begin
    nxt_clkCtl.dbgRun = avs_writedata[CLK_DBG_BIT];
    nxt_clkCtl.div = avs_writedata[CLK_DIV_LSB +: 4];
    nxt_clkCtl.src = avs_writedata[CLK_SRC_LSB +: 3];
    if (!srcPresent(avs_writedata[CLK_SRC_LSB +: 3]))
      nxt_clkCtl.src = clkCtl_ff.src; // see RULE_04
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      clkCtl_ff <= CLKCTL_RST;
    else if (clkWr)
      clkCtl_ff <= nxt_clkCtl;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cntCtl_ff <= CNTCTL_RST;
    end else if (ctlWr) begin
      cntCtl_ff.enable <= wrEnable;
      cntCtl_ff.oneShot <= avs_writedata[CTL_ONESHOT_BIT]; // see RULE_08
      cntCtl_ff.mode <= ptc_mode_t'(avs_writedata[CTL_MODE_LSB +: 2]);
    end
  end

  // source selection and edge detection of the external inputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extAPrev_ff <= 1'b0;
      extBPrev_ff <= 1'b0;
    end else begin
      extAPrev_ff <= extClockInputA;
      extBPrev_ff <= extClockInputB;
    end
  end

  always_comb begin
    srcTick = 1'b0;
    case (clkCtl_ff.src) // see RULE_03
      3'h0: srcTick = internalFastOscTick;
      3'h1: srcTick = lowSpeedOscTick;
      3'h2: srcTick = highSpeedOscTick;
      3'h3: srcTick = externalOscTick;
      3'h4: srcTick = extClockInputA && !extAPrev_ff;
      3'h5: srcTick = extClockInputB && !extBPrev_ff;
      3'h6: srcTick = !extClockInputA && extAPrev_ff;
      3'h7: srcTick = !extClockInputB && extBPrev_ff;
      default: srcTick = 1'b0;
    endcase
  end

  assign chanClkOn = cntCtl_ff.enable // see RULE_16
                     && (!debugMode || clkCtl_ff.dbgRun); // see RULE_01
  assign mask = divMask(clkCtl_ff.src, clkCtl_ff.div); // see RULE_02
  assign opTick = srcTick && chanClkOn && ((pre_ff & mask) == mask);

  // prescaler restarts whenever the clock setup is rewritten
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      pre_ff <= '0;
    else if (clkWr)
      pre_ff <= '0;
    else if (srcTick && chanClkOn)
      pre_ff <= pre_ff + PRE_W'(1); // see RULE_02
  end

  // MAX value: written word is held, then moved into use on the next operating clock tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      maxReg_ff <= MAX_RST; // see RULE_17
    else if (maxWr)
      maxReg_ff <= avs_writedata[15:0];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      maxBuf_ff <= MAX_RST; // see RULE_17
      maxBusy_ff <= 1'b0;
    end else if (maxWr) begin
      maxBusy_ff <= 1'b1; // see RULE_05
    end else if (maxBusy_ff && opTick) begin
      maxBuf_ff <= maxReg_ff;
      maxBusy_ff <= 1'b0; // see RULE_05
    end
  end

  // preset request waits for the next operating clock tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      presetBusy_ff <= 1'b0;
    else if (ctlWr && wrEnable && avs_writedata[CTL_PRESET_BIT])
      presetBusy_ff <= 1'b1; // see RULE_14 RULE_15
    else if (opTick)
      presetBusy_ff <= 1'b0; // see RULE_14
  end

  assign atMax = count_ff >= maxBuf_ff;
  assign atZero = count_ff == CNT_ZERO;
  assign runTick = opTick && run_ff && !presetBusy_ff;

  always_comb begin
    oneShotStop = 1'b0;
    if (runTick && cntCtl_ff.oneShot) begin
      case (cntCtl_ff.mode) // see RULE_11
        PTC_UP: oneShotStop = atMax;
        PTC_DOWN: oneShotStop = atZero;
        PTC_UPDN: oneShotStop = !dirUp_ff && atZero;
        default: oneShotStop = 1'b0;
      endcase
    end
  end

  // a software write with channel_enable 1 in the same cycle wins over the one-shot clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      run_ff <= 1'b0;
    else if (ctlWr && wrEnable)
      run_ff <= avs_writedata[CTL_RUN_BIT]; // see RULE_09 RULE_10 RULE_15
    else if (oneShotStop)
      run_ff <= 1'b0; // see RULE_11
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= CNT_RST; // see RULE_21
      dirUp_ff <= 1'b1;
      maxEventPulse <= 1'b0;
      zeroEventPulse <= 1'b0;
    end else begin
      maxEventPulse <= 1'b0;
      zeroEventPulse <= 1'b0;
      if (opTick && presetBusy_ff) begin
        dirUp_ff <= 1'b1;
        if (cntCtl_ff.mode == PTC_DOWN)
          count_ff <= maxBuf_ff; // see RULE_13
        else
          count_ff <= CNT_ZERO; // see RULE_12
      end else if (runTick) begin
        case (cntCtl_ff.mode) // see RULE_07
          PTC_UP: begin
            if (atMax) begin
              maxEventPulse <= 1'b1;
              if (!cntCtl_ff.oneShot)
                count_ff <= CNT_ZERO; // see RULE_08
            end else begin
              count_ff <= count_ff + 16'h0001;
            end
          end
          PTC_DOWN: begin
            if (atZero) begin
              zeroEventPulse <= 1'b1;
              if (!cntCtl_ff.oneShot)
                count_ff <= maxBuf_ff; // see RULE_08
            end else begin
              count_ff <= count_ff - 16'h0001;
            end
          end
          PTC_UPDN: begin
            if (dirUp_ff) begin
              if (atMax) begin
                maxEventPulse <= 1'b1;
                dirUp_ff <= 1'b0;
                count_ff <= count_ff - 16'h0001;
              end else begin
                count_ff <= count_ff + 16'h0001;
              end
            end else if (atZero) begin
              zeroEventPulse <= 1'b1;
              if (!cntCtl_ff.oneShot) begin
                dirUp_ff <= 1'b1;
                count_ff <= count_ff + 16'h0001;
              end
            end else begin
              count_ff <= count_ff - 16'h0001;
            end
          end
          default: count_ff <= count_ff;
        endcase
      end
    end
  end

  assign countValue = count_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      capLvl_ff <= 6'h00;
    else
      capLvl_ff <= captureInputPin & CAP_PRESENT; // see RULE_22 RULE_23
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence reqWaiting;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence oneAnswer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (reqWaiting |=> oneAnswer)
    else $error("bus answer not one cycle after request");
  debug_gate_a: assert property ( // see RULE_01
    debugMode && !clkCtl_ff.dbgRun |-> !opTick)
    else $error("count tick during debug without debug run");
  enable_gate_a: assert property ( // see RULE_16
    !cntCtl_ff.enable |-> !opTick ##1 $stable(count_ff))
    else $error("counter moved while channel disabled");
  max_busy_a: assert property ( // see RULE_05
    maxWr |=> maxBusy_ff && $stable(maxBuf_ff))
    else $error("max busy not raised after MAX write");
  run_start_a: assert property ( // see RULE_09
    ctlWr && wrEnable && avs_writedata[CTL_RUN_BIT] |=> run_ff)
    else $error("run not set by enabled write");
  run_locked_a: assert property ( // see RULE_15
    ctlWr && !wrEnable |=> run_ff == ($past(run_ff) && !$past(oneShotStop))
      && presetBusy_ff == ($past(presetBusy_ff) && !$past(opTick)))
    else $error("run or preset changed with channel disabled");
  run_stop_a: assert property ( // see RULE_10
    ctlWr && wrEnable && !avs_writedata[CTL_RUN_BIT] |=> !run_ff ##1 !runTick)
    else $error("counter still running after stop write");
  one_shot_a: assert property ( // see RULE_11
    oneShotStop && !ctlWr |=> !run_ff && $stable(count_ff))
    else $error("one-shot did not stop at its end event");
  preset_zero_a: assert property ( // see RULE_12
    opTick && presetBusy_ff && cntCtl_ff.mode != PTC_DOWN
      |=> count_ff == CNT_ZERO && presetBusy_ff == $past(ctlWr
      && wrEnable && avs_writedata[CTL_PRESET_BIT]))
    else $error("preset did not clear counter");
  preset_max_a: assert property ( // see RULE_13
    opTick && presetBusy_ff && cntCtl_ff.mode == PTC_DOWN
      |=> count_ff == $past(maxBuf_ff))
    else $error("down preset did not load MAX value");
  cap_level_a: assert property ( // see RULE_23
    $past(rst_n) |-> capLvl_ff == ($past(captureInputPin) & CAP_PRESENT))
    else $error("capture level status wrong");
  low_div_a: assert property ( // see RULE_02
    clkCtl_ff.src == SRC_LOW_SPEED && clkCtl_ff.div > LOW_SPEED_DIV_MAX
      && srcTick && chanClkOn |-> opTick)
    else $error("low-speed source divided above code 8");
  src_absent_a: assert property ( // see RULE_04
    clkWr && !srcPresent(avs_writedata[CLK_SRC_LSB +: 3])
      |=> $stable(clkCtl_ff.src))
    else $error("absent clock source was selected");
endmodule : ptc_timer_ctrl

// >>> dv/ptc_timer_ctrl_tb_top.sv
`timescale 1ns/100ps
module ptc_timer_ctrl_tb_top;
  import ptc_pkg::*;

  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, debugMode;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, c1;
  logic internalFastOscTick, lowSpeedOscTick, highSpeedOscTick;
  logic externalOscTick, extClockInputA, extClockInputB;
  logic maxEventPulse, zeroEventPulse;
  logic [5:0] captureInputPin;
  logic [15:0] countValue, ev;
  logic [2:0] srcM;
  int bad_count, n_checks, m, md, nMax, nZero, pm, pz;
  int rstExp[$] = '{0, 0, 'hffff, 0, 2, 0};
  // {debug mode at 24, rate shift at 20:16 (31 = frozen), clock control}
  logic [31:0] rows[12] = '{32'h001f_00f0, 32'h0000_00f1, 32'h0000_00f2,
    32'h0000_00f3, 32'h0001_0004, 32'h0001_0005, 32'h0001_0006,
    32'h0001_0007, 32'h0002_0020, 32'h0008_0081, 32'h011f_0001,
    32'h0100_0101};

  // high-speed oscillator and capture input 5 are left out of this build
  ptc_timer_ctrl #(.SRC_PRESENT(6'h3b), .CAP_PRESENT(6'h1f)) dut_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .debugMode(debugMode),
    .internalFastOscTick(internalFastOscTick),
    .lowSpeedOscTick(lowSpeedOscTick),
    .highSpeedOscTick(highSpeedOscTick),
    .externalOscTick(externalOscTick),
    .extClockInputA(extClockInputA),
    .extClockInputB(extClockInputB),
    .captureInputPin(captureInputPin),
    .countValue(countValue),
    .maxEventPulse(maxEventPulse),
    .zeroEventPulse(zeroEventPulse)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // external clock inputs give one rising and one falling edge per 2 cycles
  always @(posedge core_clk) begin
    extClockInputA <= ~extClockInputA;
    extClockInputB <= ~extClockInputB;
  end

  // bench count of MAX and zero event pulses
  always @(posedge core_clk) begin
    if (maxEventPulse === 1'b1)
      nMax++;
    if (zeroEventPulse === 1'b1)
      nZero++;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen,
               exp);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [2:0] a,
                      input logic [15:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    logic [31:0] dummy;
    xfer(1'b1, a, v, dummy);
  endtask : wr

  task automatic rdchk(input logic [2:0] a, input logic [15:0] e,
                       input string what);
    logic [31:0] v;
    xfer(1'b0, a, 16'h0000, v);
    chk(v, {16'h0000, e}, what);
  endtask : rdchk

  task automatic poll(input logic [2:0] a, input int b);
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      xfer(1'b0, a, 16'h0000, v);
      n++;
    end while (v[b] !== 1'b0 && n < 400);
    chk(32'(v[b]), 32'h0, "flag clears");
  endtask : poll

  // counter advance over about 203 cycles against a source rate of 1/2^sh
  task automatic rate(input int sh);
    logic [31:0] a, b;
    int dl;
    xfer(1'b0, IDX_CNT_VAL, 16'h0000, a);
    repeat (200) @(posedge core_clk);
    xfer(1'b0, IDX_CNT_VAL, 16'h0000, b);
    dl = int'(b[15:0] - a[15:0]);
    chk(32'(dl >= (195 >> sh) - 2 && dl <= (210 >> sh) + 2), 32'h1, "rate");
  endtask : rate

  initial begin
    #(50000 * 10);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0000_0000;
    debugMode = 1'b0;
    internalFastOscTick = 1'b1;
    lowSpeedOscTick = 1'b1;
    highSpeedOscTick = 1'b1;
    externalOscTick = 1'b1;
    extClockInputA = 1'b0;
    extClockInputB = 1'b1;
    bad_count = 0;
    n_checks = 0;
    srcM = 3'h0;
    void'($urandom(32'h8c0c));
    captureInputPin = 6'($urandom);
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      ev = 16'(rstExp[i]);
      if (i == 4) ev = ev | {8'h00, captureInputPin & 6'h1f, 2'b00};
      rdchk(3'(i), ev, "reset value");
    end
    wr(IDX_CNT_CTL, 16'h0006);
    rdchk(IDX_CNT_CTL, 16'h0000, "run while disabled");
    wr(IDX_CNT_CTL, 16'h0001);
    m = 10 + $urandom % 20;
    wr(IDX_MAX_VAL, 16'(m));
    poll(IDX_CNT_CTL, CTL_MAX_LOAD_BUSY_BIT);
    rdchk(IDX_MAX_VAL, 16'(m), "max readback");
    for (md = 0; md < 3; md++) begin
      captureInputPin <= 6'($urandom);
      wr(IDX_CNT_CTL, 16'(md << 4 | 3));
      poll(IDX_CNT_CTL, CTL_PRESET_BIT);
      rdchk(IDX_CNT_VAL, md == 1 ? 16'(m) : 16'h0000,
            "preset");
      rdchk(IDX_CNT_STS, {8'h00, captureInputPin & 6'h1f, md != 1, 1'b0},
            "status");
      pm = nMax;
      pz = nZero;
      wr(IDX_CNT_CTL, 16'(md << 4 | 'hd));
      rdchk(IDX_CNT_CTL, 16'(md << 4 | 'hd), "running");
      poll(IDX_CNT_CTL, CTL_RUN_BIT);
      rdchk(IDX_CNT_VAL, md == 0 ? 16'(m) : 16'h0000,
            "one-shot end");
      chk(32'(countValue), md == 0 ? 32'(m) : 32'h0, "count port");
      chk(32'(nMax - pm), 32'(md != 1), "max events");
      chk(32'(nZero - pz), 32'(md != 0), "zero events");
    end
    pm = nMax;
    wr(IDX_CNT_CTL, 16'h0005);
    repeat (3 * m) @(posedge core_clk);
    rdchk(IDX_CNT_CTL, 16'h0005, "repeat keeps running");
    chk(32'(nMax - pm >= 2), 32'h1, "repeat wraps");
    wr(IDX_CNT_CTL, 16'h0001);
    xfer(1'b0, IDX_CNT_VAL, 16'h0000, c1);
    repeat (20) @(posedge core_clk);
    rdchk(IDX_CNT_VAL, c1[15:0], "stopped");
    wr(IDX_CNT_CTL, 16'h0035);
    repeat (20) @(posedge core_clk);
    rdchk(IDX_CNT_VAL, c1[15:0], "reserved mode holds");
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk(IDX_MAX_VAL, 16'hffff, "max after reset");
    wr(IDX_CNT_CTL, 16'h0005);
    for (int i = 0; i < 12; i++) begin
      debugMode <= rows[i][24];
      wr(IDX_CLK_CTL, rows[i][15:0]);
      ev = rows[i][15:0];
      if (ev[2:0] == 3'h2) ev[2:0] = srcM;
      else srcM = ev[2:0];
      rdchk(IDX_CLK_CTL, ev, "clock control");
      rate(int'(rows[i][20:16]));
    end
    debugMode <= 1'b0;
    wr(IDX_CNT_CTL, 16'h0000);
    rate(31);
    tally_and_finish();
  end
endmodule : ptc_timer_ctrl_tb_top
